/* File: hdl/pfc_core.sv */
// Program flow controller: fetch, decode, loops, interrupts, register port
//
// The register offsets and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/1ps
module pfc_core #(
    parameter int NUM_PERIPH = 4
) (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    output logic [15:0] pmem_addr_o,
    input wire logic [15:0] pmem_data_i,
    input wire logic ext_int_line_a_i,
    input wire logic ext_int_line_b_i,
    input wire logic [NUM_PERIPH-1:0] periph_irq_i,
    input wire logic [NUM_PERIPH-1:0] periph_lvl_i,
    input wire logic [16*NUM_PERIPH-1:0] periph_vec_i,
    output logic exc_taken_o,
    output logic [15:0] exc_vector_o,
    output logic sstk_we_o,
    output logic [15:0] sstk_addr_o,
    output logic [15:0] sstk_data_o,
    output logic agu_valid_o,
    output logic [3:0] agu_op_o,
    output logic [11:0] agu_arg_o,
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o
);
    import pfc_pkg::*;

    localparam int NSRC = NUM_PERIPH + 2;

    typedef struct packed {
        pfc_state_t fsm;
        logic [15:0] pc;
        logic [15:0] ir;
        logic [15:0] sr;
        logic [15:0] la;
        logic [LC_W-1:0] lc;
        logic [15:0] operating_mode_word;
        logic [15:0] sp;
        logic [15:0] sp_pend;
        logic sp_pend_v;
        logic [15:0] bf_val;
        logic bf_pend;
        logic [1:0][15:0] loop_return_stack;
        logic [1:0] hws_cnt;
        logic [15:0] ctrl;
        logic sstk_we;
        logic [15:0] sstk_addr;
        logic [15:0] sstk_data;
        logic agu_v;
        logic [3:0] agu_op;
        logic [11:0] agu_arg;
        logic exc;
        logic [15:0] vec;
        logic wait_r;
        logic [31:0] rdata;
    } pfc_st_t;

    pfc_st_t st_reg;
    pfc_st_t st_next;
    logic [3:0] op_ir;
    logic [3:0] op_f;
    logic [11:0] arg;
    logic run_now;
    logic stall;
    logic redirect;
    logic [15:0] tgt;
    logic take;
    logic take_ok;
    logic fetch_go;
    logic [15:0] hws_top;
    logic found;
    logic best_lvl;
    logic [15:0] best_vec;
    logic cur_ipl;
    logic [NSRC-1:0] src_req;
    logic [NSRC-1:0] src_lvl;
    logic bus_req;

    // Outputs straight from the state flops
    assign pmem_addr_o = st_reg.pc;
    assign exc_taken_o = st_reg.exc;
    assign exc_vector_o = st_reg.vec;
    assign sstk_we_o = st_reg.sstk_we;
    assign sstk_addr_o = st_reg.sstk_addr;
    assign sstk_data_o = st_reg.sstk_data;
    assign agu_valid_o = st_reg.agu_v;
    assign agu_op_o = st_reg.agu_op;
    assign agu_arg_o = st_reg.agu_arg;
    assign avs_readdata_o = st_reg.rdata;
    assign avs_waitrequest_o = st_reg.wait_r;

    // Request arbitration and priority check
    always_comb begin
        src_req = {periph_irq_i, ext_int_line_b_i, ext_int_line_a_i};
        src_lvl = {periph_lvl_i, st_reg.ctrl[CTRL_LVLB_BIT],
                   st_reg.ctrl[CTRL_LVLA_BIT]};
        found = 1'b0;
        best_lvl = 1'b0;
        best_vec = VEC_EXT_A;
        // Downward scan so the lowest index wins a tie
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (src_req[i] && (!found || src_lvl[i] >= best_lvl)) begin
                found = 1'b1;
                best_lvl = src_lvl[i];
                if (i == 0) begin
                    best_vec = VEC_EXT_A;
                end else if (i == 1) begin
                    best_vec = VEC_EXT_B;
                end else begin
                    best_vec = periph_vec_i[16*(i-2) +: 16];
                end
            end
        end
        // Any mask bit set raises the core to level 1
        cur_ipl = st_reg.sr[SR_I1_BIT] | st_reg.sr[SR_I0_BIT];
        // Request level plus one must exceed the core level
        take = found && ({1'b0, best_lvl} + 2'd1 > {1'b0, cur_ipl});
    end

    // Next-state logic for fetch, decode, loops, exceptions and bus
    always_comb begin
        st_next = st_reg;
        st_next.sstk_we = 1'b0;
        st_next.agu_v = 1'b0;
        st_next.exc = 1'b0;
        op_ir = pfc_opc(st_reg.ir);
        op_f = pfc_opc(pmem_data_i);
        arg = st_reg.ir[11:0];
        hws_top = st_reg.hws_cnt[1] ? st_reg.loop_return_stack[1] : st_reg.loop_return_stack[0];
        run_now = (st_reg.fsm == PFC_RUN) && st_reg.ctrl[CTRL_RUN_BIT];
        redirect = 1'b0;
        tgt = {4'h0, arg};
        stall = run_now && op_ir == OP_OFF_WR && op_f == OP_ADDR_USE
                && pmem_data_i[ARG_USES_OFF_BIT];
        fetch_go = 1'b0;
        take_ok = take;
        bus_req = avs_read_i | avs_write_i;

        // Bus slave: one wait cycle, write lands when waitrequest is low
        st_next.wait_r = ~(bus_req & st_reg.wait_r);
        if (avs_read_i && st_reg.wait_r) begin
            case (avs_address_i)
                REG_PC: st_next.rdata = {16'h0000, st_reg.pc};
                REG_SR: st_next.rdata = {16'h0000, st_reg.sr};
                REG_LA: st_next.rdata = {16'h0000, st_reg.la};
                REG_LC: st_next.rdata = {19'h00000, st_reg.lc};
                REG_OMR: st_next.rdata = {16'h0000, st_reg.operating_mode_word};
                REG_IR: st_next.rdata = {16'h0000, st_reg.ir};
                REG_CTRL: st_next.rdata = {16'h0000, st_reg.ctrl};
                REG_STAT: st_next.rdata = {14'h0000, st_reg.hws_cnt, st_reg.vec};
                default: st_next.rdata = 32'h0000_0000;
            endcase
        end
        if (avs_write_i && !st_reg.wait_r) begin
            case (avs_address_i)
                REG_SR: st_next.sr = avs_writedata_i[15:0];
                REG_LA: st_next.la = avs_writedata_i[15:0];
                REG_LC: st_next.lc = avs_writedata_i[LC_W-1:0];
                REG_OMR: st_next.operating_mode_word = avs_writedata_i[15:0];
                REG_CTRL: st_next.ctrl = avs_writedata_i[15:0];
                default: ;
            endcase
        end

        case (st_reg.fsm)
            // Reset processing holds off arbitration for one cycle
            PFC_RESET: begin
                st_next.pc = VEC_RESET;
                st_next.ir = NOP_WORD;
                st_next.fsm = PFC_RUN;
            end
            PFC_RUN: begin
                if (run_now) begin
                    // A pending stack pointer write lands unless a call follows
                    if (st_reg.sp_pend_v && op_ir != OP_CALL) begin
                        st_next.sp = st_reg.sp_pend;
                        st_next.sp_pend_v = 1'b0;
                    end
                    // Address-unit ops go out in order; an offset use right after an offset write waits one bubble
                    if (op_ir == OP_PTR_WR || op_ir == OP_MOD_WR
                        || op_ir == OP_OFF_WR || op_ir == OP_ADDR_USE) begin
                        st_next.agu_v = 1'b1;
                        st_next.agu_op = op_ir;
                        st_next.agu_arg = arg;
                    end
                    case (op_ir)
                        OP_SP_WR: begin
                            st_next.sp_pend_v = 1'b1;
                            st_next.sp_pend = {4'h0, arg};
                        end
                        OP_CALL: begin
                            // Return address saved with the old pointer
                            st_next.sstk_we = 1'b1;
                            st_next.sstk_addr = st_reg.sp;
                            st_next.sstk_data = st_reg.pc;
                            st_next.sp = st_reg.sp + 16'h0001;
                            st_next.sp_pend_v = 1'b0;
                            redirect = 1'b1;
                        end
                        OP_JMP: redirect = 1'b1;
                        OP_BIT_FIELD_SET_OP_SR: begin
                            // First cycle reads the status word
                            st_next.bf_pend = 1'b1;
                            st_next.bf_val = st_reg.sr | (arg[ARG_BF_HIGH_BIT]
                                ? {arg[7:0], 8'h00} : {8'h00, arg[7:0]});
                        end
                        OP_DO: begin
                            // Full stack drops the push
                            if (st_reg.hws_cnt != 2'd2) begin
                                st_next.loop_return_stack[st_reg.hws_cnt[0]] = st_reg.pc;
                                st_next.hws_cnt = st_reg.hws_cnt + 2'd1;
                            end
                            st_next.operating_mode_word[OMR_NL_BIT] = st_reg.sr[SR_LF_BIT];
                            st_next.sr[SR_LF_BIT] = 1'b1;
                            st_next.la = st_reg.pc
                                + {12'h000, arg[ARG_DO_LEN_MSB:ARG_DO_LEN_LSB]};
                            st_next.lc = {5'h00, arg[7:0]};
                        end
                        OP_ENDDO: begin
                            st_next.sr[SR_LF_BIT] = st_reg.operating_mode_word[OMR_NL_BIT];
                            st_next.operating_mode_word[OMR_NL_BIT] = 1'b0;
                            if (st_reg.hws_cnt != 2'd0) begin
                                st_next.hws_cnt = st_reg.hws_cnt - 2'd1;
                            end
                        end
                        default: ;
                    endcase
                    // Second cycle writes back, overriding the loop flag set
                    if (st_reg.bf_pend) begin
                        st_next.sr = st_reg.bf_val;
                        st_next.bf_pend = (op_ir == OP_BIT_FIELD_SET_OP_SR);
                    end
                    // Exceptions wait for flow changes and status write-back
                    if (op_ir == OP_CALL || op_ir == OP_JMP || op_ir == OP_DO
                        || op_ir == OP_BIT_FIELD_SET_OP_SR || op_ir == OP_SP_WR
                        || st_reg.sp_pend_v || st_reg.bf_pend || stall) begin
                        take_ok = 1'b0;
                    end
                    // Fetch path
                    if (redirect) begin
                        st_next.pc = tgt;
                        st_next.ir = NOP_WORD;
                    end else if (take_ok) begin
                        st_next.sstk_we = 1'b1;
                        st_next.sstk_addr = st_reg.sp;
                        st_next.sstk_data = st_reg.pc;
                        st_next.sp = st_reg.sp + 16'h0001;
                        st_next.pc = best_vec;
                        st_next.vec = best_vec;
                        st_next.exc = 1'b1;
                        st_next.sr[SR_I1_BIT] = 1'b1;
                        st_next.sr[SR_I0_BIT] = 1'b1;
                        st_next.ir = NOP_WORD;
                    end else if (stall) begin
                        st_next.ir = NOP_WORD;
                    end else begin
                        fetch_go = 1'b1;
                        st_next.ir = pmem_data_i;
                        st_next.pc = st_reg.pc + 16'h0001;
                        // Loop end checked only while the loop flag is set
                        if (st_reg.sr[SR_LF_BIT] && st_reg.pc == st_reg.la) begin
                            if (st_reg.lc != 13'h0001) begin
                                st_next.lc = st_reg.lc - 13'h0001;
                                st_next.pc = hws_top;
                            end else begin
                                st_next.sr[SR_LF_BIT] = st_reg.operating_mode_word[OMR_NL_BIT];
                                st_next.operating_mode_word[OMR_NL_BIT] = 1'b0;
                                if (st_reg.hws_cnt != 2'd0) begin
                                    st_next.hws_cnt = st_reg.hws_cnt - 2'd1;
                                end
                            end
                        end
                    end
                end
            end
            default: st_next.fsm = PFC_RESET;
        endcase
    end

    // State register; reset loads the reset processing state
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_reg <= '0;
            st_reg.fsm <= PFC_RESET;
            st_reg.pc <= VEC_RESET;
            st_reg.sr <= SR_RST;
            st_reg.operating_mode_word <= OMR_RST;
            st_reg.sp <= SP_RST;
            st_reg.ctrl <= CTRL_RST;
            st_reg.wait_r <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // Offset hazard inserts a bubble and holds the fetch address
    property p_off_stall;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        stall |=> (st_reg.ir == NOP_WORD) && (st_reg.pc == $past(st_reg.pc));
    endproperty
    a_off_stall: assert property (p_off_stall) else $error("no offset stall");

    // Call after stack pointer write uses the old pointer
    property p_sp_call;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (run_now && op_ir == OP_CALL && st_reg.sp_pend_v) |=>
            sstk_we_o && sstk_addr_o == $past(st_reg.sp)
            && st_reg.sp == $past(st_reg.sp) + 16'h0001 && !st_reg.sp_pend_v;
    endproperty
    a_sp_call: assert property (p_sp_call) else $error("call used new sp");

    // Bit-field read then write-back one cycle later
    property p_bf_two;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (run_now && op_ir == OP_BIT_FIELD_SET_OP_SR) ##1 run_now |=>
            st_reg.sr == $past(st_reg.bf_val);
    endproperty
    a_bf_two: assert property (p_bf_two) else $error("bad bit-field timing");

    // Write-back beats the loop flag set in the same cycle
    property p_lf_override;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (run_now && st_reg.bf_pend && op_ir == OP_DO) |=>
            st_reg.sr[SR_LF_BIT] == $past(st_reg.bf_val[SR_LF_BIT]);
    endproperty
    a_lf_override: assert property (p_lf_override) else $error("lf override");

    // Loop start pushes, copies the flag into the nested bit and sets it
    property p_do_start;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (run_now && !st_reg.bf_pend && op_ir == OP_DO && st_reg.hws_cnt != 2'd2)
        |=> st_reg.sr[SR_LF_BIT]
            && st_reg.hws_cnt == $past(st_reg.hws_cnt) + 2'd1
            && st_reg.operating_mode_word[OMR_NL_BIT] == $past(st_reg.sr[SR_LF_BIT])
            && hws_top == $past(st_reg.pc);
    endproperty
    a_do_start: assert property (p_do_start) else $error("bad loop start");

    // With the loop flag clear a plain fetch never branches back
    property p_loop_gate;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (fetch_go && !st_reg.sr[SR_LF_BIT]) |=>
            st_reg.pc == $past(st_reg.pc) + 16'h0001;
    endproperty
    a_loop_gate: assert property (p_loop_gate) else $error("loop after end");

    // A level 0 request is taken only with both mask bits clear
    property p_irq_mask;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (st_reg.exc && !$past(best_lvl)) |->
            $past(st_reg.sr[SR_I1_BIT:SR_I0_BIT]) == 2'b00;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("masked irq taken");

    // Reset state starts at the reset vector with no exception
    property p_reset;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (st_reg.fsm == PFC_RESET) |=>
            st_reg.fsm == PFC_RUN && st_reg.pc == VEC_RESET && !exc_taken_o;
    endproperty
    a_reset: assert property (p_reset) else $error("reset not honoured");

    // Exception pushes the fetch address and jumps to the chosen vector
    property p_exc_push;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        exc_taken_o |-> sstk_we_o && pmem_addr_o == exc_vector_o
            && sstk_data_o == $past(st_reg.pc);
    endproperty
    a_exc_push: assert property (p_exc_push) else $error("bad exception");
endmodule : pfc_core

/* File: hdl/pfc_pkg.sv */
// Shared constants, opcode codes and state type of the program flow controller
package pfc_pkg;
    // Opcode field of an instruction word
    localparam int OPC_MSB = 15;
    localparam int OPC_LSB = 12;
    localparam logic [3:0] OP_NOP = 4'h0;
    localparam logic [3:0] OP_PTR_WR = 4'h1;
    localparam logic [3:0] OP_MOD_WR = 4'h2;
    localparam logic [3:0] OP_OFF_WR = 4'h3;
    localparam logic [3:0] OP_ADDR_USE = 4'h4;
    localparam logic [3:0] OP_SP_WR = 4'h5;
    localparam logic [3:0] OP_CALL = 4'h6;
    localparam logic [3:0] OP_BIT_FIELD_SET_OP_SR = 4'h7;
    localparam logic [3:0] OP_DO = 4'h8;
    localparam logic [3:0] OP_JMP = 4'h9;
    localparam logic [3:0] OP_ENDDO = 4'hA;
    localparam logic [15:0] NOP_WORD = 16'h0000;
    // Argument field positions
    localparam int ARG_USES_OFF_BIT = 11;
    localparam int ARG_BF_HIGH_BIT = 8;
    localparam int ARG_DO_LEN_MSB = 11;
    localparam int ARG_DO_LEN_LSB = 8;
    // Status word, mode word fields and reset values
    localparam int SR_LF_BIT = 15;
    localparam int SR_I1_BIT = 9;
    localparam int SR_I0_BIT = 8;
    localparam int OMR_NL_BIT = 15;
    localparam logic [15:0] SR_RST = 16'h0300;
    localparam logic [15:0] OMR_RST = 16'h0000;
    localparam logic [15:0] SP_RST = 16'h0000;
    localparam logic [15:0] VEC_RESET = 16'h0000;
    localparam logic [15:0] VEC_EXT_A = 16'h0010;
    localparam logic [15:0] VEC_EXT_B = 16'h0012;
    localparam int LC_W = 13;
    // Register byte offsets
    localparam logic [7:0] REG_PC = 8'h00;
    localparam logic [7:0] REG_SR = 8'h04;
    localparam logic [7:0] REG_LA = 8'h08;
    localparam logic [7:0] REG_LC = 8'h0C;
    localparam logic [7:0] REG_OMR = 8'h10;
    localparam logic [7:0] REG_IR = 8'h14;
    localparam logic [7:0] REG_CTRL = 8'h18;
    localparam logic [7:0] REG_STAT = 8'h1C;
    // Control register fields
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_LVLA_BIT = 1;
    localparam int CTRL_LVLB_BIT = 2;
    localparam logic [15:0] CTRL_RST = 16'h0001;

    typedef enum logic [1:0] {PFC_RESET, PFC_RUN} pfc_state_t;

    // Opcode of an instruction word
    function automatic logic [3:0] pfc_opc(input logic [15:0] w);
        return w[OPC_MSB:OPC_LSB];
    endfunction : pfc_opc
endpackage : pfc_pkg

/* File: testbench/pfc_prog_mem.sv */
// Program memory and peripheral request model for the flow controller bench
`timescale 1ns/1ps
module pfc_prog_mem #(
    parameter int NUM_PERIPH = 4
) (
    input wire logic [15:0] addr_i,
    output logic [15:0] data_o,
    output logic [NUM_PERIPH-1:0] irq_o,
    output logic [NUM_PERIPH-1:0] lvl_o,
    output logic [16*NUM_PERIPH-1:0] vec_o
);
    logic [15:0] mem [0:255];
    // Combinational read; unloaded cells hold a no-op word
    assign data_o = mem[addr_i[7:0]];
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 16'h0000;
        end
        irq_o = '0;
        lvl_o = '0;
        vec_o = '0;
    end
    // A peripheral raises a level-1 request and offers its own vector
    task automatic periph_req(input int n, input logic on,
                              input logic [15:0] v);
        irq_o[n] <= on;
        lvl_o[n] <= 1'b1;
        vec_o[16*n +: 16] <= v;
    endtask : periph_req
endmodule : pfc_prog_mem

/* File: testbench/tb_program_flow_controller.sv */
// Self-checking bench for the program flow controller
`timescale 1ns/1ps
module tb_program_flow_controller;
    import pfc_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic ext_a = 1'b0, ext_b = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic [15:0] pmem_addr_o, pmem_data_i, exc_vector_o, sstk_addr_o, r16;
    logic [15:0] exp_v = 16'hFFFF;
    logic [15:0] sstk_data_o;
    logic [11:0] agu_arg_o;
    logic [15:0] dq[$], oq[$];
    logic [3:0] irq, lvl, agu_op_o;
    logic [63:0] vec;
    logic exc_taken_o, sstk_we_o, agu_valid_o, avs_waitrequest_o;
    logic [7:0] avs_address = 8'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata_o, rd;
    int err_total = 0, checked = 0, cyc = 0, n_exc = 0, c46 = 0, c4a = 0;
    int seed = 32'h91d6;
    int aq[$];
    logic [15:0] sq[$];
    // Program: sp write + call, offset/pointer/modifier hazards, two loops
    // The first addr-use word reads the offset just written; the later two read other registers
    localparam logic [31:0] PROG [0:21] = '{32'h0000_5005, 32'h0001_6040,
        32'h0040_3000, 32'h0041_4800, 32'h0042_1000, 32'h0043_4000,
        32'h0044_7100, 32'h0045_8108, 32'h0046_0000, 32'h0047_2000,
        32'h0048_4000, 32'h0049_8103, 32'h004A_0000, 32'h004B_0000,
        32'h004C_0000, 32'h004D_904C, 32'h0010_0000, 32'h0011_9010,
        32'h0012_0000, 32'h0013_9012, 32'h0077_0000, 32'h0078_9077};
    always #2 clk_sys_i = ~clk_sys_i;
    pfc_core pfc_core_inst (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
        .pmem_addr_o(pmem_addr_o), .pmem_data_i(pmem_data_i),
        .ext_int_line_a_i(ext_a), .ext_int_line_b_i(ext_b),
        .periph_irq_i(irq), .periph_lvl_i(lvl), .periph_vec_i(vec),
        .exc_taken_o(exc_taken_o), .exc_vector_o(exc_vector_o),
        .sstk_we_o(sstk_we_o), .sstk_addr_o(sstk_addr_o),
        .sstk_data_o(sstk_data_o),
        .agu_valid_o(agu_valid_o), .agu_op_o(agu_op_o),
        .agu_arg_o(agu_arg_o),
        .avs_address_i(avs_address), .avs_read_i(avs_read),
        .avs_write_i(avs_write), .avs_writedata_i(avs_writedata),
        .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o));
    pfc_prog_mem pfc_prog_mem_inst (.addr_i(pmem_addr_o),
        .data_o(pmem_data_i), .irq_o(irq), .lvl_o(lvl), .vec_o(vec));
    task automatic finish_test();
        $display("checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // One bus access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 40);
        rd = avs_readdata_o;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (n >= 40) begin
            chk("bus_wait", 0, 1);
            finish_test();
        end
    endtask : bus
    // Raise requests until one exception is seen, then drop them all
    task automatic take(input logic [2:0] ctl, input logic a, input logic b,
                        input logic p, input logic [15:0] v);
        int n;
        bus(1'b1, REG_CTRL, {29'h0, ctl});
        exp_v = v;
        n_exc = 0;
        n = 0;
        ext_a <= a;
        ext_b <= b;
        pfc_prog_mem_inst.periph_req(0, p, 16'h0077);
        while (n_exc == 0 && n < 60) begin
            @(posedge clk_sys_i);
            n++;
        end
        chk("exc_seen", 1, n_exc > 0);
        ext_a <= 1'b0;
        ext_b <= 1'b0;
        pfc_prog_mem_inst.periph_req(0, 1'b0, 16'h0077);
        repeat (8) @(posedge clk_sys_i);
    endtask : take
    // Reference side: fetch counts, issue times, pushes, vectors
    always @(posedge clk_sys_i) begin
        cyc++;
        if (rst_b_i) begin
            if (pmem_addr_o === 16'h0046) c46++;
            if (pmem_addr_o === 16'h004A) c4a++;
            if (agu_valid_o === 1'b1) begin
                aq.push_back(cyc);
                oq.push_back({agu_op_o, agu_arg_o});
            end
            if (sstk_we_o === 1'b1) begin
                sq.push_back(sstk_addr_o);
                dq.push_back(sstk_data_o);
            end
            if (exc_taken_o === 1'b1) begin
                n_exc++;
                chk("exc_vector", exp_v, exc_vector_o);
            end
        end
    end
    initial begin
        #100000;
        chk("run_time", 0, 1);
        finish_test();
    end
    // Main sequence
    initial begin
        #1;
        foreach (PROG[i]) begin
            pfc_prog_mem_inst.mem[PROG[i][23:16]] = PROG[i][15:0];
        end
        repeat (8) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        bus(1'b0, REG_SR, 0);
        chk("sr_reset", 32'h0300, rd);
        bus(1'b0, REG_CTRL, 0);
        chk("ctrl_reset", 32'h1, rd);
        bus(1'b0, 8'h20, 0);
        chk("unmapped", 0, rd);
        repeat (60) @(posedge clk_sys_i);
        chk("loop_once", 1, c46);
        chk("loop_three", 3, c4a);
        chk("off_stall", 2, aq[1] - aq[0]);
        chk("ptr_no_stall", 1, aq[3] - aq[2]);
        chk("call_sp", 0, sq[0]);
        chk("call_ret", 16'h0002, dq[0]);
        chk("mod_no_stall", 1, aq[5] - aq[4]);
        chk("agu_ops", {OP_OFF_WR, OP_ADDR_USE, OP_PTR_WR},
            {oq[0][15:12], oq[1][15:12], oq[2][15:12]});
        chk("agu_ops2", {OP_ADDR_USE, OP_MOD_WR, OP_ADDR_USE},
            {oq[3][15:12], oq[4][15:12], oq[5][15:12]});
        chk("agu_arg", {OP_ADDR_USE, 12'h800}, oq[1]);
        bus(1'b0, REG_SR, 0);
        chk("loop_flag", 0, rd[15]);
        r16 = 16'($random(seed));
        bus(1'b1, REG_LA, {16'h0, r16});
        bus(1'b0, REG_LA, 0);
        chk("la_rw", {16'h0, r16}, rd);
        bus(1'b1, REG_LC, {16'h0, r16});
        bus(1'b0, REG_LC, 0);
        chk("lc_rw", {16'h0, r16 & 16'h1FFF}, rd);
        // Level-0 request against the raised mask: no exception
        ext_a <= 1'b1;
        repeat (20) @(posedge clk_sys_i);
        ext_a <= 1'b0;
        chk("masked", 0, n_exc);
        take(3'b011, 1'b1, 1'b0, 1'b0, VEC_EXT_A);
        chk("irq_sp", 1, sq[1]);
        take(3'b101, 1'b0, 1'b1, 1'b1, VEC_EXT_B);
        take(3'b001, 1'b0, 1'b0, 1'b1, 16'h0077);
        // Mask bits cleared by software: a level-0 request is taken
        bus(1'b1, REG_SR, 0);
        take(3'b001, 1'b1, 1'b0, 1'b0, VEC_EXT_A);
        // Reset in mid-run with a level-1 request standing
        bus(1'b1, REG_CTRL, 32'h3);
        exp_v = 16'hFFFF;
        n_exc = 0;
        ext_a <= 1'b1;
        rst_b_i <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
        chk("pc_reset", 0, pmem_addr_o);
        rst_b_i <= 1'b1;
        bus(1'b0, REG_CTRL, 0);
        chk("ctrl_again", 32'h1, rd);
        ext_a <= 1'b0;
        chk("reset_no_exc", 0, n_exc);
        finish_test();
    end
endmodule : tb_program_flow_controller
